// File: hdl/lvrc_pkg.sv
package lvrc_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_VDET_CTRL = 8'hbf;  // voltage_detect_control
  localparam logic [7:0]  ADDR_AUX_TWO   = 8'hf7;  // auxiliary_control_two
  localparam logic [7:0]  ADDR_AUX_ONE   = 8'hf8;  // auxiliary_control_one
  localparam logic [7:0]  ADDR_IRQ_FLAG  = 8'h95;  // interrupt_flag_register
  localparam logic [7:0]  ADDR_SW_CMD    = 8'h97;  // software_reset_command
  localparam logic [15:0] ADDR_CFG_HIGH  = 16'h7fff; // config_word_high

  // ----------------------------------------------------------------
  // command values, field positions, reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SW_RESET_KEY   = 8'h56;
  localparam logic [7:0] IRQ_CLEAR_KEY  = 8'h7f;
  localparam int         VDET_IE_BIT    = 7;
  localparam int         VDET_RES_BIT   = 6;
  localparam int         IRQ_FLAG_BIT   = 7;
  localparam int         AUXILIARY_CONTROL_ONE_WDCLR_BIT = 7;
  localparam int         AUXILIARY_CONTROL_ONE_URDIS_BIT = 3;
  localparam int         AUXILIARY_CONTROL_TWO_WDHI_BIT  = 7;
  localparam int         AUXILIARY_CONTROL_TWO_WDLO_BIT  = 6;
  localparam int         AUXILIARY_CONTROL_TWO_PSAV_BIT  = 5;
  localparam int         CFG_PINDIS_BIT = 6;
  localparam int         CFG_LVL_HI     = 5;
  localparam int         CFG_LVL_LO     = 3;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [3:0] VDET_SEL_RESET = 4'h0;
  localparam logic [7:0] CFG_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SY_PIN = 0;
  localparam int SY_SRC = 1;
  localparam int SY_LVD = 2;
  localparam int SY_LVR = 3;
  localparam int SY_POR = 4;
  localparam int SY_W   = 5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned POR_HOLD_MS  = 40;
  localparam int unsigned POR_HOLD_CYC = POR_HOLD_MS * (CLK_HZ / 1000);
  localparam logic [1:0]  PIN_MIN_SRC  = 2'h2;   // slow oscillator cycles
  localparam logic [3:0]  RST_PULSE    = 4'hf;   // internal reset stretch

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PM_FAST, PM_SLOW, PM_IDLE, PM_HALT, PM_STOP} lvrc_pmode_e;
  typedef enum logic [1:0] {LM_OFF, LM_POR, LM_THRESH} lvrc_lvr_e;
  typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_RUN} lvrc_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } lvrc_sfr_s;

endpackage

// File: hdl/lvrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module lvrc_top
  import lvrc_pkg::*;
#(
  parameter int unsigned P_POR_HOLD_CYC = POR_HOLD_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire lvrc_sfr_s   i_sfr,
  output logic [7:0]       o_sfr_rdata,
  input  wire lvrc_pmode_e i_power_mode,
  input  wire logic        i_ext_irq_en,
  input  wire logic        i_wdt_overflow,
  input  wire logic        i_pin_reset_n,
  input  wire logic        i_slow_osc,
  input  wire logic        i_lvr_below,
  input  wire logic        i_por_below,
  input  wire logic        i_lvd_below,
  input  wire logic        i_cfg_valid,
  input  wire logic [7:0]  i_cfg_data,
  output logic             o_cfg_req,
  output logic [15:0]      o_cfg_addr,
  output logic [2:0]       o_lvr_level,
  output var lvrc_lvr_e    o_lvr_mode,
  output logic [3:0]       o_lvd_level,
  output logic             o_lvd_irq,
  output logic             o_wdt_clear,
  output logic             o_chip_rst_n
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SY_W-1:0] sync1_q, sync2_q;
  logic [SY_W-1:0] sync1_d, sync2_d;

  // comparators, pin and slow oscillator are all asynchronous here
  always_comb begin
    sync1_d = {i_por_below, i_lvr_below, i_lvd_below, i_slow_osc, i_pin_reset_n};
    sync2_d = sync1_q;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= 5'h01;
      sync2_q <= 5'h01;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // ----------------------------------------------------------------
  // main state
  // ----------------------------------------------------------------
  lvrc_state_e state_q, state_d;
  logic [19:0] por_cnt_q, por_cnt_d;
  logic [7:0]  cfg_q, cfg_d;
  logic        cfg_req_q, cfg_req_d;
  logic [3:0]  pulse_q, pulse_d;
  logic        chip_rst_n_q, chip_rst_n_d;
  logic        vdet_ie_q, vdet_ie_d;
  logic [3:0]  vdet_sel_q, vdet_sel_d;
  logic [7:0]  auxiliary_control_one_q, auxiliary_control_one_d;
  logic [7:0]  auxiliary_control_two_q, auxiliary_control_two_d;
  logic        flag_q, flag_d;
  logic        irq_q, irq_d;
  logic [7:0]  rdata_q, rdata_d;
  lvrc_lvr_e   lvr_mode_q, lvr_mode_d;
  logic        src_prev_q, src_prev_d;
  logic        lvd_prev_q, lvd_prev_d;
  logic [1:0]  pin_cnt_q, pin_cnt_d;

  logic run, wr_ok, awake, sw_evt, pin_evt, wdt_evt, lvr_evt, rst_evt, lvd_rise, src_rise;

  // reset sources and undervolt reset mode selection
  always_comb begin
    run      = (state_q == ST_RUN);
    awake    = (i_power_mode == PM_FAST) || (i_power_mode == PM_SLOW);
    src_rise = sync2_q[SY_SRC] && !src_prev_q;
    lvd_rise = sync2_q[SY_LVD] && !lvd_prev_q;
    sw_evt   = run && i_sfr.wr && (i_sfr.addr == ADDR_SW_CMD)
               && (i_sfr.wdata == SW_RESET_KEY);
    pin_evt  = run && !sync2_q[SY_PIN] && (pin_cnt_q == PIN_MIN_SRC)
               && !cfg_q[CFG_PINDIS_BIT];
    wdt_evt  = run && i_wdt_overflow && auxiliary_control_two_q[AUXILIARY_CONTROL_TWO_WDHI_BIT]
               && (auxiliary_control_two_q[AUXILIARY_CONTROL_TWO_WDLO_BIT] || awake);
    if (auxiliary_control_one_q[AUXILIARY_CONTROL_ONE_URDIS_BIT]) begin
      lvr_mode_d = (awake || i_power_mode == PM_IDLE) ? LM_POR : LM_OFF;
    end else if (awake || !auxiliary_control_two_q[AUXILIARY_CONTROL_TWO_PSAV_BIT]) begin
      lvr_mode_d = LM_THRESH;
    end else begin
      lvr_mode_d = (i_power_mode == PM_IDLE) ? LM_POR : LM_OFF;
    end
    lvr_evt  = run && (((lvr_mode_d == LM_THRESH) && sync2_q[SY_LVR])
               || ((lvr_mode_d == LM_POR) && sync2_q[SY_POR]));
    rst_evt  = sw_evt || pin_evt || wdt_evt || lvr_evt;
    wr_ok    = run && i_sfr.wr && !rst_evt;
  end

  // next values for sequencing, registers and read data
  always_comb begin
    state_d    = state_q;
    por_cnt_d  = por_cnt_q;
    cfg_d      = cfg_q;
    cfg_req_d  = 1'b0;
    src_prev_d = sync2_q[SY_SRC];
    lvd_prev_d = sync2_q[SY_LVD];
    // power-on hold, then one config fetch before release
    case (state_q)
      ST_HOLD: begin
        por_cnt_d = por_cnt_q + 20'h1;
        if (por_cnt_q == 20'(P_POR_HOLD_CYC - 1)) begin
          state_d   = ST_LOAD;
          cfg_req_d = 1'b1;
        end
      end
      ST_LOAD: begin
        cfg_req_d = !i_cfg_valid;
        if (i_cfg_valid) begin
          cfg_d   = i_cfg_data;
          state_d = ST_RUN;
        end
      end
      ST_RUN:  state_d = ST_RUN;
      default: state_d = ST_HOLD;
    endcase
    // count rising slow edges while the pin is low; any high restarts the count
    if (sync2_q[SY_PIN]) begin
      pin_cnt_d = 2'h0;
    end else if (src_rise && pin_cnt_q != PIN_MIN_SRC) begin
      pin_cnt_d = pin_cnt_q + 2'h1;
    end else begin
      pin_cnt_d = pin_cnt_q;
    end
    // stretch so a one-cycle software or watchdog event still resets the chip
    if (rst_evt) begin
      pulse_d = RST_PULSE;
    end else if (pulse_q != 4'h0) begin
      pulse_d = pulse_q - 4'h1;
    end else begin
      pulse_d = pulse_q;
    end
    chip_rst_n_d = run && !rst_evt && (pulse_q == 4'h0);
    // registers: watchdog clear bit self-clears after one cycle
    vdet_ie_d  = vdet_ie_q;
    vdet_sel_d = vdet_sel_q;
    auxiliary_control_one_d     = auxiliary_control_one_q;
    auxiliary_control_one_d[AUXILIARY_CONTROL_ONE_WDCLR_BIT] = 1'b0;
    auxiliary_control_two_d     = auxiliary_control_two_q;
    flag_d     = flag_q;
    if (wr_ok) begin
      case (i_sfr.addr)
        ADDR_VDET_CTRL: begin
          vdet_ie_d  = i_sfr.wdata[VDET_IE_BIT];
          vdet_sel_d = i_sfr.wdata[3:0];
        end
        ADDR_AUX_ONE:  auxiliary_control_one_d = i_sfr.wdata;
        ADDR_AUX_TWO:  auxiliary_control_two_d = i_sfr.wdata;
        ADDR_IRQ_FLAG: flag_d = (i_sfr.wdata == IRQ_CLEAR_KEY) ? 1'b0 : flag_q;
        default:       flag_d = flag_q;
      endcase
    end
    if (lvd_rise) begin
      flag_d = 1'b1;
    end
    // every SFR register back to default on any internal reset; cfg_q keeps its value
    if (rst_evt) begin
      vdet_ie_d  = 1'b0;
      vdet_sel_d = VDET_SEL_RESET;
      auxiliary_control_one_d     = REG_RESET;
      auxiliary_control_two_d     = REG_RESET;
      flag_d     = 1'b0;
    end
    irq_d = flag_q && vdet_ie_q && i_ext_irq_en;
    case (i_sfr.addr)
      ADDR_VDET_CTRL: rdata_d = {vdet_ie_q, sync2_q[SY_LVD], 2'h0, vdet_sel_q};
      ADDR_AUX_ONE:   rdata_d = auxiliary_control_one_q;
      ADDR_AUX_TWO:   rdata_d = auxiliary_control_two_q;
      ADDR_IRQ_FLAG:  rdata_d = {flag_q, 7'h00};
      default:        rdata_d = 8'h00;
    endcase
  end

  // power-on reset is the asynchronous reset itself
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q      <= ST_HOLD;
      por_cnt_q    <= 20'h0;
      cfg_q        <= CFG_RESET;
      cfg_req_q    <= 1'b0;
      pulse_q      <= 4'h0;
      chip_rst_n_q <= 1'b0;
      vdet_ie_q    <= 1'b0;
      vdet_sel_q   <= VDET_SEL_RESET;
      auxiliary_control_one_q       <= REG_RESET;
      auxiliary_control_two_q       <= REG_RESET;
      flag_q       <= 1'b0;
      irq_q        <= 1'b0;
      rdata_q      <= 8'h00;
      lvr_mode_q   <= LM_THRESH;
      src_prev_q   <= 1'b0;
      lvd_prev_q   <= 1'b0;
      pin_cnt_q    <= 2'h0;
    end else begin
      state_q      <= state_d;
      por_cnt_q    <= por_cnt_d;
      cfg_q        <= cfg_d;
      cfg_req_q    <= cfg_req_d;
      pulse_q      <= pulse_d;
      chip_rst_n_q <= chip_rst_n_d;
      vdet_ie_q    <= vdet_ie_d;
      vdet_sel_q   <= vdet_sel_d;
      auxiliary_control_one_q       <= auxiliary_control_one_d;
      auxiliary_control_two_q       <= auxiliary_control_two_d;
      flag_q       <= flag_d;
      irq_q        <= irq_d;
      rdata_q      <= rdata_d;
      lvr_mode_q   <= lvr_mode_d;
      src_prev_q   <= src_prev_d;
      lvd_prev_q   <= lvd_prev_d;
      pin_cnt_q    <= pin_cnt_d;
    end
  end

  // outputs straight from flops except the constant o_cfg_addr; the analog trims read the stored codes
  assign o_sfr_rdata  = rdata_q;
  assign o_cfg_req    = cfg_req_q;
  assign o_cfg_addr   = ADDR_CFG_HIGH;
  assign o_lvr_level  = cfg_q[CFG_LVL_HI:CFG_LVL_LO];
  assign o_lvr_mode   = lvr_mode_q;
  assign o_lvd_level  = vdet_sel_q;
  assign o_lvd_irq    = irq_q;
  assign o_wdt_clear  = auxiliary_control_one_q[AUXILIARY_CONTROL_ONE_WDCLR_BIT];
  assign o_chip_rst_n = chip_rst_n_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  a_sw_reset: assert property (sw_evt |=> !o_chip_rst_n [*8])
    else $error("software reset did not hold chip reset");
  a_por_hold: assert property (state_q != ST_RUN |-> !o_chip_rst_n)
    else $error("chip reset released before config load");
  a_pin_reset: assert property (pin_evt |=> !o_chip_rst_n && auxiliary_control_one_q == REG_RESET)
    else $error("pin reset not honoured");
  // with the pin ignored and no other source active the chip must stay out of reset
  a_pin_masked: assert property (cfg_q[CFG_PINDIS_BIT] && run && !sw_evt && !wdt_evt
                                 && !lvr_evt && pulse_q == 4'h0 |=> o_chip_rst_n)
    else $error("disabled pin reset took effect");
  a_wdt_idle: assert property (auxiliary_control_two_q[7:6] == 2'h2 && !awake |-> !wdt_evt)
    else $error("watchdog reset in sleep with fast-slow setting");
  a_lvr_off: assert property (auxiliary_control_one_q[AUXILIARY_CONTROL_ONE_URDIS_BIT] |=> o_lvr_mode != LM_THRESH)
    else $error("threshold reset active while disabled");
  a_lvr_psave: assert property (!auxiliary_control_one_q[3] && auxiliary_control_two_q[5] && i_power_mode == PM_HALT
                                |=> o_lvr_mode == LM_OFF)
    else $error("undervolt reset kept in halt with power saving");
  a_irq_gate: assert property (!i_ext_irq_en || !vdet_ie_q |=> !o_lvd_irq)
    else $error("detect interrupt raised while disabled");
  a_flag_set: assert property (lvd_rise && !rst_evt |=> flag_q)
    else $error("detect flag not set by hardware");
  a_flag_clear: assert property (wr_ok && i_sfr.addr == ADDR_IRQ_FLAG
                                 && i_sfr.wdata == IRQ_CLEAR_KEY && !lvd_rise |=> !flag_q)
    else $error("detect flag not cleared");
  a_result_read: assert property (i_sfr.addr == ADDR_VDET_CTRL
                                  |=> o_sfr_rdata[6] == $past(sync2_q[SY_LVD]))
    else $error("detect result bit wrong on read");
  a_release: assert property (run && !rst_evt && pulse_q == 4'h0 |=> o_chip_rst_n)
    else $error("chip reset not released");

  c_sw_reset: cover property (sw_evt ##1 !o_chip_rst_n);
  c_pin_reset: cover property (pin_evt);
  c_cfg_load: cover property (state_q == ST_LOAD && i_cfg_valid);
  c_lvd_irq: cover property (o_lvd_irq);

endmodule
`default_nettype wire

// File: dv/tb_low_voltage_and_reset_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_low_voltage_and_reset_control;
  import lvrc_pkg::*;
  localparam int P_HOLD = 20;
  // --------------------------------
  // signals and device
  // --------------------------------
  logic        clk, nrst, ext_ie, wdt_ovf, pin_rst_n, slow_osc;
  logic        lvr_below, por_below, lvd_below, cfg_valid;
  logic        cfg_req, lvd_irq, wdt_clear, chip_rst_n;
  logic [7:0]  cfg_data, rdata;
  logic [15:0] cfg_addr;
  logic [2:0]  lvr_level;
  logic [3:0]  lvd_level;
  lvrc_sfr_s   sfr;
  lvrc_pmode_e pmode;
  lvrc_lvr_e   lvr_mode;
  int          bad_count, checks_done, low_cnt;
  lvrc_top #(.P_POR_HOLD_CYC(P_HOLD)) i_dut (
    .i_ref_clk(clk), .i_nrst(nrst), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .i_power_mode(pmode), .i_ext_irq_en(ext_ie), .i_wdt_overflow(wdt_ovf),
    .i_pin_reset_n(pin_rst_n), .i_slow_osc(slow_osc), .i_lvr_below(lvr_below),
    .i_por_below(por_below), .i_lvd_below(lvd_below), .i_cfg_valid(cfg_valid),
    .i_cfg_data(cfg_data), .o_cfg_req(cfg_req), .o_cfg_addr(cfg_addr),
    .o_lvr_level(lvr_level), .o_lvr_mode(lvr_mode), .o_lvd_level(lvd_level),
    .o_lvd_irq(lvd_irq), .o_wdt_clear(wdt_clear), .o_chip_rst_n(chip_rst_n));
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // counts chip reset cycles; sampled on the falling edge to stay clear of updates
  always @(negedge clk) begin
    if (chip_rst_n === 1'b0) low_cnt++;
  end
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clk);
    sfr.wr <= 1'b0;
  endtask
  // read data lags the address by a cycle, so wait two edges before looking
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr <= '{addr: a, wr: 1'b0, wdata: 8'h00};
    tick(2);
    #1 check($sformatf("read %h", a), {8'h00, exp}, {8'h00, rdata});
  endtask
  function automatic lvrc_lvr_e lvr_exp(input logic u, input logic p, input int m);
    if (u) return (m <= 2) ? LM_POR : LM_OFF;
    if (m <= 1 || !p) return LM_THRESH;
    return (m == 2) ? LM_POR : LM_OFF;
  endfunction
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic power_up(input logic [7:0] cfg);
    int n;
    @(posedge clk);
    nrst <= 1'b0;
    tick(3);
    #1 check("por chip reset", 16'h0, 16'(chip_rst_n));
    check("por cfg request", 16'h0, 16'(cfg_req));
    @(posedge clk);
    nrst <= 1'b1;
    n = 0;
    while (cfg_req !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    check("hold length ok", 16'h1, 16'(n >= P_HOLD - 1 && n <= P_HOLD + 3));
    check("held before load", 16'h0, 16'(chip_rst_n));
    check("cfg address", 16'h7fff, cfg_addr);
    @(posedge clk);
    cfg_data <= cfg;
    cfg_valid <= 1'b1;
    @(posedge clk);
    cfg_valid <= 1'b0;
    // the run state is entered at the fetch edge, release follows one edge later
    @(posedge clk);
    #1 check("release after load", 16'h1, 16'(chip_rst_n));
    check("request dropped", 16'h0, 16'(cfg_req));
    check("reset level code", 16'(cfg[5:3]), 16'(lvr_level));
  endtask
  task automatic sw_reset_regs();
    wr(ADDR_VDET_CTRL, 8'hc5);
    wr(ADDR_AUX_TWO, 8'h2a);
    wr(ADDR_AUX_ONE, 8'h08);
    rd_chk(ADDR_VDET_CTRL, 8'h85);
    rd_chk(ADDR_AUX_TWO, 8'h2a);
    rd_chk(ADDR_AUX_ONE, 8'h08);
    rd_chk(8'h90, 8'h00);
    // watchdog clear bit is a one-cycle pulse after the write
    wr(ADDR_AUX_ONE, 8'h80);
    #1 check("watchdog clear pulse", 16'h1, 16'(wdt_clear));
    @(posedge clk);
    #1 check("watchdog clear drops", 16'h0, 16'(wdt_clear));
    low_cnt = 0;
    wr(ADDR_SW_CMD, 8'h55);
    tick(20);
    check("no reset on other key", 16'h0, 16'(low_cnt));
    low_cnt = 0;
    wr(ADDR_SW_CMD, SW_RESET_KEY);
    tick(30);
    check("sw reset length", 16'd16, 16'(low_cnt));
    rd_chk(ADDR_VDET_CTRL, 8'h00);
    rd_chk(ADDR_AUX_TWO, 8'h00);
    rd_chk(ADDR_AUX_ONE, 8'h00);
    #1 check("level kept", 16'h5, 16'(lvr_level));
  endtask
  task automatic watchdog_codes();
    lvrc_pmode_e modes[4] = '{PM_FAST, PM_SLOW, PM_IDLE, PM_STOP};
    for (int c = 0; c < 4; c++) begin
      for (int m = 0; m < 4; m++) begin
        @(posedge clk);
        pmode <= modes[m];
        wr(ADDR_AUX_TWO, {c[1:0], 6'h00});
        low_cnt = 0;
        @(posedge clk);
        wdt_ovf <= 1'b1;
        @(posedge clk);
        wdt_ovf <= 1'b0;
        tick(25);
        check($sformatf("watchdog %0d mode %0d", c, m), 16'(c == 3 || (c == 2 && m < 2)),
              16'(low_cnt != 0));
      end
    end
  endtask
  task automatic supply_dip(input logic undervolt_reset, input logic por, input logic exp);
    low_cnt = 0;
    @(posedge clk);
    lvr_below <= undervolt_reset;
    por_below <= por;
    tick(3);
    lvr_below <= 1'b0;
    por_below <= 1'b0;
    tick(25);
    check("undervolt reset", 16'(exp), 16'(low_cnt != 0));
  endtask
  task automatic lvr_table();
    for (int i = 0; i < 20; i++) begin
      wr(ADDR_AUX_ONE, {4'h0, i[4], 3'h0});
      wr(ADDR_AUX_TWO, {2'h0, i[3], 5'h00});
      @(posedge clk);
      pmode <= lvrc_pmode_e'(3'(i % 5));
      tick(3);
      #1 check($sformatf("undervolt mode %0d", i), 16'(lvr_exp(i[4], i[3], i % 5)),
               16'(lvr_mode));
    end
    supply_dip(1'b1, 1'b1, 1'b0);
    @(posedge clk);
    pmode <= PM_FAST;
    supply_dip(1'b0, 1'b1, 1'b1);
    supply_dip(1'b1, 1'b0, 1'b1);
  endtask
  task automatic irq_flow();
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_VDET_CTRL, {4'h0, i[3:0]});
      tick(2);
      #1 check("detect level", 16'(i), 16'(lvd_level));
    end
    @(posedge clk);
    ext_ie <= 1'b1;
    wr(ADDR_VDET_CTRL, 8'h80);
    lvd_below <= 1'b1;
    tick(8);
    #1 check("irq raised", 16'h1, 16'(lvd_irq));
    rd_chk(ADDR_VDET_CTRL, 8'hc0);
    rd_chk(ADDR_IRQ_FLAG, 8'h80);
    @(posedge clk);
    ext_ie <= 1'b0;
    tick(3);
    #1 check("irq ext masked", 16'h0, 16'(lvd_irq));
    @(posedge clk);
    ext_ie <= 1'b1;
    wr(ADDR_VDET_CTRL, 8'h00);
    tick(3);
    #1 check("irq enable masked", 16'h0, 16'(lvd_irq));
    wr(ADDR_VDET_CTRL, 8'h80);
    wr(ADDR_IRQ_FLAG, 8'hff);
    rd_chk(ADDR_IRQ_FLAG, 8'h80);
    wr(ADDR_IRQ_FLAG, IRQ_CLEAR_KEY);
    rd_chk(ADDR_IRQ_FLAG, 8'h00);
    #1 check("irq cleared", 16'h0, 16'(lvd_irq));
    @(posedge clk);
    lvd_below <= 1'b0;
    rd_chk(ADDR_VDET_CTRL, 8'h80);
  endtask
  // the pin is released only after the slow oscillator has made its edges
  task automatic pin_pulse(input int edges, input logic exp);
    low_cnt = 0;
    @(posedge clk);
    pin_rst_n <= 1'b0;
    repeat (2 * edges) begin
      tick(4);
      slow_osc <= ~slow_osc;
    end
    tick(6);
    pin_rst_n <= 1'b1;
    tick(30);
    check($sformatf("pin reset %0d edges", edges), 16'(exp), 16'(low_cnt != 0));
  endtask
  // --------------------------------
  // run control
  // --------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, more than ten times the expected run length
  initial begin
    tick(20000);
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    {nrst, ext_ie, wdt_ovf, slow_osc, lvr_below, por_below, lvd_below, cfg_valid} = '0;
    {pin_rst_n, cfg_data, bad_count, checks_done, low_cnt} = '0;
    pin_rst_n = 1'b1;
    sfr = '0;
    pmode = PM_FAST;
    for (int l = 0; l < 8; l++) power_up({2'b00, 3'(l), 3'b000});
    power_up(8'h28);
    sw_reset_regs();
    irq_flow();
    watchdog_codes();
    lvr_table();
    pin_pulse(1, 1'b0);
    pin_pulse(3, 1'b1);
    power_up(8'h40);
    pin_pulse(3, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
